// ==== core/twes_pkg.sv ====
package twes_pkg;

	// Protocol states of the slave
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_DEV_ACK,
		ST_WADDR,
		ST_WADDR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RACK,
		ST_RACK_OK,
		ST_IGNORE
	} twes_state_t;

	// Array shape
	localparam int ARRAY_BYTES = 256;
	localparam int PAGE_BYTES = 8;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// Fixed upper nibble of the device address word
	localparam logic [3:0] DEV_CODE = 4'hA;

	// Pin positions inside the synchroniser vector
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_COUNT = 3;
	localparam logic [2:0] PIN_RESET = 3'h3;

	// Timing
	localparam int CLK_MHZ = 50;
	localparam int WRITE_CYCLE_TIME_US = 5000;
	localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_TIME_US * CLK_MHZ;

endpackage

// ==== core/twes_pins_if.sv ====
`timescale 1ns/100ps
interface twes_pins_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda;
	logic wp;

	modport src (output scl_rise, output scl_fall, output start, output stop, output sda, output wp);
	modport dst (input scl_rise, input scl_fall, input start, input stop, input sda, input wp);
endinterface

// ==== core/twes_pin_sync.sv ====
`timescale 1ns/100ps
module twes_pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Raw pins
	input wire logic [twes_pkg::PIN_COUNT-1:0] pins_in,
	// Filtered events
	twes_pins_if.src ev
);
	localparam int N = twes_pkg::PIN_COUNT;

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} twes_sync_t;

	twes_sync_t q;
	twes_sync_t d;
	logic [N-1:0] nxt;

	// Accept a new level once the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			assign nxt[g] = (q.s2[g] == q.s3[g]) ? q.s2[g] : q.lvl[g];
		end
	endgenerate

	// Shift chain and edge detection
	always_comb begin
		d = q;
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = nxt;
		d.scl_rise = nxt[twes_pkg::PIN_SCL] & ~q.lvl[twes_pkg::PIN_SCL];
		d.scl_fall = ~nxt[twes_pkg::PIN_SCL] & q.lvl[twes_pkg::PIN_SCL];
		// SDA moving while SCL stays high is a bus condition, not data
		d.start = q.lvl[twes_pkg::PIN_SCL] & nxt[twes_pkg::PIN_SCL] &
			q.lvl[twes_pkg::PIN_SDA] & ~nxt[twes_pkg::PIN_SDA];
		d.stop = q.lvl[twes_pkg::PIN_SCL] & nxt[twes_pkg::PIN_SCL] &
			~q.lvl[twes_pkg::PIN_SDA] & nxt[twes_pkg::PIN_SDA];
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '{s1: twes_pkg::PIN_RESET, s2: twes_pkg::PIN_RESET, s3: twes_pkg::PIN_RESET,
				lvl: twes_pkg::PIN_RESET, default: 1'b0};
		end else if (ce) begin
			q <= d;
		end
	end

	assign ev.scl_rise = q.scl_rise;
	assign ev.scl_fall = q.scl_fall;
	assign ev.start = q.start;
	assign ev.stop = q.stop;
	assign ev.sda = q.lvl[twes_pkg::PIN_SDA];
	assign ev.wp = q.lvl[twes_pkg::PIN_WP];

endmodule

// ==== core/twes_core.sv ====
`timescale 1ns/100ps
// What this block does
// - SDA changing while SCL is high is a start or stop, never data.
// - SDA falling with SCL high is a start; every command begins with one.
// - SDA rising with SCL high is a stop; after a read it gives standby.
// - Words are eight bits, MSB first; device pulls SDA low in ninth clock.
// - Standby after power-up and after a stop once writes finish.
// - Device address follows each start; upper nibble fixed, next three ignored.
// - Address LSB one means read, zero means write.
// - Matching device address is acknowledged in the next slot.
// - Byte write is address, word address, one data byte, then stop.
// - Stop after a write starts a self-timed cycle; inputs ignored meanwhile.
// - Page write takes up to eight bytes, each acknowledged, then a stop.
// - Write address increments only its low three bits, wrapping in page.
// - Polling start plus address is acknowledged only when programming ends.
// - Address counter keeps last accessed address plus one between operations.
// - Read address wraps from the last byte to the first.
// - Current read sends the byte at the counter; host nacks and stops.
// - Each host acknowledge increments the address and sends the next byte.
// - Bits sampled on rising SCL, output changes after falling SCL.
// - Write-protect high blocks all writes to the array.
// - Array is 256 bytes in 32 pages of eight, eight-bit address.
module twes_core #(
	parameter int WRITE_CYCLES = twes_pkg::WRITE_CYCLE_CLKS
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Write protect pin
	input wire logic wp_in,
	// Status
	output logic standby,
	output logic prog_busy
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);

	// Parameter check
	generate
		if (WRITE_CYCLES < 1) begin : g_bad
			$error("WRITE_CYCLES must be at least one");
		end
	endgenerate

	typedef struct packed {
		twes_pkg::twes_state_t st;
		logic [2:0] bitcnt;
		logic got8;
		logic [7:0] shift;
		logic [7:0] addr;
		logic [4:0] page;
		logic [7:0][7:0] pbuf;
		logic [7:0] pmask;
		logic rd;
		logic oe;
		logic busy;
		logic [TW-1:0] timer;
		logic standby;
		logic [255:0][7:0] mem;
	} twes_core_t;

	twes_core_t q;
	twes_core_t d;
	twes_pins_if ev ();

	// Pin synchroniser and bus condition detector
	twes_pin_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.pins_in({wp_in, sda_in, scl_in}),
		.ev(ev)
	);

	// Protocol engine
	always_comb begin
		d = q;
		// Self-timed programming counter
		if (q.busy) begin
			if (q.timer == TW'(WRITE_CYCLES - 1)) begin
				d.busy = 1'b0;
			end else begin
				d.timer = q.timer + 1'b1;
			end
		end
		if (ev.start) begin
			// Any start restarts address reception
			d.st = twes_pkg::ST_DEV;
			d.bitcnt = 3'h0;
			d.got8 = 1'b0;
			d.oe = 1'b0;
			d.pmask = 8'h00;
		end else if (ev.stop) begin
			d.st = twes_pkg::ST_IDLE;
			d.oe = 1'b0;
			d.pmask = 8'h00;
			// Commit the page buffer unless protected or already programming
			if (q.pmask != 8'h00 && !ev.wp && !q.busy) begin
				for (int i = 0; i < twes_pkg::PAGE_BYTES; i++) begin
					if (q.pmask[i]) begin
						d.mem[{q.page, 3'(i)}] = q.pbuf[i];
					end
				end
				d.busy = 1'b1;
				d.timer = '0;
			end
		end else begin
			case (q.st)
				twes_pkg::ST_DEV, twes_pkg::ST_WADDR, twes_pkg::ST_WDATA: begin
					// Shift in MSB first on rising SCL
					if (ev.scl_rise) begin
						d.shift = {q.shift[6:0], ev.sda};
						d.bitcnt = q.bitcnt + 3'h1;
						d.got8 = (q.bitcnt == 3'h7);
					end else if (ev.scl_fall && q.got8) begin
						d.got8 = 1'b0;
						d.oe = 1'b1;
						if (q.st == twes_pkg::ST_DEV) begin
							if (q.shift[7:4] == twes_pkg::DEV_CODE && !q.busy) begin
								d.st = twes_pkg::ST_DEV_ACK;
								d.rd = q.shift[0];
							end else begin
								d.oe = 1'b0;
								d.st = twes_pkg::ST_IGNORE;
							end
						end else if (q.st == twes_pkg::ST_WADDR) begin
							d.addr = q.shift;
							d.page = q.shift[7:3];
							d.st = twes_pkg::ST_WADDR_ACK;
						end else begin
							// Store into the page and wrap the low bits only
							d.pbuf[q.addr[2:0]] = q.shift;
							d.pmask[q.addr[2:0]] = 1'b1;
							d.addr = {q.addr[7:3], q.addr[2:0] + 3'h1};
							d.st = twes_pkg::ST_WDATA_ACK;
						end
					end
				end
				twes_pkg::ST_DEV_ACK, twes_pkg::ST_RACK_OK: begin
					// End of acknowledge slot
					if (ev.scl_fall) begin
						d.bitcnt = 3'h0;
						if (q.rd) begin
							d.shift = q.mem[q.addr];
							d.oe = ~q.mem[q.addr][7];
							d.addr = q.addr + 8'h01;
							d.st = twes_pkg::ST_RDATA;
						end else begin
							d.oe = 1'b0;
							d.st = twes_pkg::ST_WADDR;
						end
					end
				end
				twes_pkg::ST_WADDR_ACK, twes_pkg::ST_WDATA_ACK: begin
					if (ev.scl_fall) begin
						d.oe = 1'b0;
						d.bitcnt = 3'h0;
						d.st = twes_pkg::ST_WDATA;
					end
				end
				twes_pkg::ST_RDATA: begin
					// Count host clocks, move to the next bit after each fall
					if (ev.scl_rise) begin
						d.bitcnt = q.bitcnt + 3'h1;
						d.got8 = (q.bitcnt == 3'h7);
					end else if (ev.scl_fall) begin
						if (q.got8) begin
							d.got8 = 1'b0;
							d.oe = 1'b0;
							d.st = twes_pkg::ST_RACK;
						end else begin
							d.shift = {q.shift[6:0], 1'b0};
							d.oe = ~q.shift[6];
						end
					end
				end
				twes_pkg::ST_RACK: begin
					// Host acknowledge continues, no acknowledge waits for stop
					if (ev.scl_rise) begin
						d.st = ev.sda ? twes_pkg::ST_IGNORE : twes_pkg::ST_RACK_OK;
					end
				end
				default: begin
					d.oe = 1'b0;
				end
			endcase
		end
		d.standby = (d.st == twes_pkg::ST_IDLE) && !d.busy;
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '{st: twes_pkg::ST_IDLE, standby: 1'b1, mem: {256{twes_pkg::ERASED_BYTE}}, default: '0};
		end else if (ce) begin
			q <= d;
		end
	end

	// Outputs
	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign standby = q.standby;
	assign prog_busy = q.busy;

	// Start always returns the engine to address reception
	property p_start_dev;
		@(posedge mclk) disable iff (rst)
		(ce && ev.start) |=> (q.st == twes_pkg::ST_DEV && !q.oe);
	endproperty
	a_start_dev: assert property (p_start_dev) else $error("start did not reach address state");

	// Stop releases the line and goes idle
	property p_stop_idle;
		@(posedge mclk) disable iff (rst)
		(ce && ev.stop) |=> (q.st == twes_pkg::ST_IDLE && !q.oe);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle the engine");

	// Address acknowledge only on a match and while not programming
	property p_dev_ack;
		@(posedge mclk) disable iff (rst)
		$rose(q.st == twes_pkg::ST_DEV_ACK) |-> (q.oe && !q.busy && $past(q.shift[7:4]) == twes_pkg::DEV_CODE);
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("bad address acknowledge");

	// Mismatch or busy never drives the line
	property p_ignore_quiet;
		@(posedge mclk) disable iff (rst)
		(q.st == twes_pkg::ST_IGNORE) |-> !q.oe;
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet) else $error("drove SDA while ignoring");

	// Output changes only after a falling clock or a bus condition
	property p_oe_timing;
		@(posedge mclk) disable iff (rst)
		(ce && $changed(q.oe)) |-> $past(ev.scl_fall || ev.start || ev.stop);
	endproperty
	a_oe_timing: assert property (p_oe_timing) else $error("SDA changed outside SCL low");

	// Programming stays busy for at least two cycles once it starts
	property p_busy_hold;
		@(posedge mclk) disable iff (rst)
		$rose(q.busy) |-> q.busy[*2];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("programming cycle ended too early");

	// Protected stop never starts programming
	property p_wp_block;
		@(posedge mclk) disable iff (rst)
		(ce && ev.stop && ev.wp && !q.busy) |=> !q.busy && q.mem == $past(q.mem);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected array was written");

	// Page writes keep the page row
	property p_page_row;
		@(posedge mclk) disable iff (rst)
		$rose(q.st == twes_pkg::ST_WDATA_ACK) |-> q.addr[7:3] == $past(q.addr[7:3]);
	endproperty
	a_page_row: assert property (p_page_row) else $error("write address left its page");

	// Read counter wraps to zero
	property p_read_wrap;
		@(posedge mclk) disable iff (rst)
		$rose(q.st == twes_pkg::ST_RDATA) && $past(q.addr) == 8'hFF |-> q.addr == 8'h00;
	endproperty
	a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");

	// Standby follows idle with no programming
	property p_standby;
		@(posedge mclk) disable iff (rst)
		(q.st == twes_pkg::ST_IDLE && !q.busy) |-> q.standby;
	endproperty
	a_standby: assert property (p_standby) else $error("standby missing while idle");

	// Programming ends only when the timer has run the full cycle
	property p_busy_len;
		@(posedge mclk) disable iff (rst)
		$fell(q.busy) |-> $past(q.timer) == TW'(WRITE_CYCLES - 1);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming cycle length wrong");

	// An unprotected stop with buffered bytes starts a fresh programming cycle
	property p_commit;
		@(posedge mclk) disable iff (rst)
		(ce && ev.stop && q.pmask != 8'h00 && !ev.wp && !q.busy) |=> (q.busy && q.timer == '0);
	endproperty
	a_commit: assert property (p_commit) else $error("write stop did not start programming");

	// A busy device leaves the address slot released and ignores the transfer
	property p_busy_nack;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && q.got8 && q.st == twes_pkg::ST_DEV && q.busy) |=>
			(!q.oe && q.st == twes_pkg::ST_IGNORE);
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("busy device answered a poll");

	// A matching address is acknowledged and its direction bit kept
	property p_match_ack;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && q.got8 && q.st == twes_pkg::ST_DEV && !q.busy &&
			q.shift[7:4] == twes_pkg::DEV_CODE) |=>
			(q.oe && q.st == twes_pkg::ST_DEV_ACK && q.rd == $past(q.shift[0]));
	endproperty
	a_match_ack: assert property (p_match_ack) else $error("matching address not acknowledged");

	// The line is released when a write acknowledge slot ends
	property p_ack_release;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && (q.st == twes_pkg::ST_WADDR_ACK || q.st == twes_pkg::ST_WDATA_ACK)) |=>
			!q.oe;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("acknowledge held too long");

	// A read byte starts with the MSB at the counter, which then moves on
	property p_read_first;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && q.rd && (q.st == twes_pkg::ST_DEV_ACK || q.st == twes_pkg::ST_RACK_OK)) |=>
			(q.oe == ~$past(q.mem[q.addr][7]) && q.addr == $past(q.addr) + 8'h01);
	endproperty
	a_read_first: assert property (p_read_first) else $error("wrong first read bit");

	// Each later read bit follows after a falling clock
	property p_read_bit;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && q.st == twes_pkg::ST_RDATA && !q.got8) |=> q.oe == ~$past(q.shift[6]);
	endproperty
	a_read_bit: assert property (p_read_bit) else $error("wrong read bit order");

	// No host acknowledge ends the read and frees the line
	property p_host_nack;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_rise && ev.sda && q.st == twes_pkg::ST_RACK) |=>
			(q.st == twes_pkg::ST_IGNORE && !q.oe);
	endproperty
	a_host_nack: assert property (p_host_nack) else $error("read went on after no acknowledge");

	// A host acknowledge continues the sequential read
	property p_host_ack;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_rise && !ev.sda && q.st == twes_pkg::ST_RACK) |=> q.st == twes_pkg::ST_RACK_OK;
	endproperty
	a_host_ack: assert property (p_host_ack) else $error("read stopped after acknowledge");

	// Each written byte steps only the low three address bits
	property p_write_wrap;
		@(posedge mclk) disable iff (rst)
		(ce && ev.scl_fall && q.got8 && q.st == twes_pkg::ST_WDATA) |=>
			(q.addr[7:3] == $past(q.addr[7:3]) && q.addr[2:0] == $past(q.addr[2:0]) + 3'h1);
	endproperty
	a_write_wrap: assert property (p_write_wrap) else $error("write address stepped wrongly");

endmodule

// ==== sim/twes_host.sv ====
`timescale 1ns/100ps
// Bus master model: drives SCL, pulls SDA low, reports each byte or acknowledge
module twes_host (
	// Clock
	input wire logic mclk,
	// Bus
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	// Results
	output logic res_valid,
	output logic res_is_ack,
	output logic [7:0] res_data
);
	// Idle bus: SCL high, SDA released, no result pending
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res_is_ack = 1'b0;
		res_data = 8'h00;
	end
	// Wait whole clocks, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// SCL low is stretched so the slave's output latency fits before the rise
	task automatic bitc(input logic b, output logic r);
		sda_low = ~b;
		tick(10);
		scl = 1'b1;
		tick(4);
		r = sda;
		scl = 1'b0;
		tick(2);
	endtask
	// Waits out a slave acknowledge before raising SCL
	task automatic start();
		sda_low = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b1;
		tick(6);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		tick(6);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b0;
		tick(8);
	endtask
	// Free a stuck bus with nine clocks, then a start
	task automatic recover();
		logic r;
		for (int i = 0; i < 9; i++) bitc(1'b1, r);
		start();
	endtask
	task automatic report(input logic a, input logic [7:0] d);
		res_is_ack = a;
		res_data = d;
		res_valid = 1'b1;
		tick(1);
		res_valid = 1'b0;
	endtask
	// Send MSB first, then release SDA for the ninth clock
	task automatic wbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitc(d[i], r);
		bitc(1'b1, r);
		report(1'b1, {7'h00, ~r});
	endtask
	// Receive a byte; acknowledge to go on, leave SDA high to end
	task automatic rbyte(input logic more);
		logic r;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) begin
			bitc(1'b1, r);
			d[i] = r;
		end
		bitc(~more, r);
		report(1'b0, d);
	endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
// Drives the slave through the host model and checks every result
module testbench;
	localparam int WC = 400;
	logic mclk, rst, ce, wp_in, sda_out, sda_oe, standby, prog_busy;
	logic scl, sda_low, sda, res_valid, res_is_ack;
	logic [7:0] res_data, b0;
	logic [7:0] pg [0:9];
	logic [8:0] notes [$];
	logic [31:0] run_len = 0, busy_len = 0;
	int error_cnt = 0, samples_checked = 0, seed = 32'h3FEB4C27, hold = 0;
	// Open-drain wire with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	twes_core #(.WRITE_CYCLES(WC)) DUT (.mclk(mclk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .standby(standby), .prog_busy(prog_busy));
	twes_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low), .res_valid(res_valid),
		.res_is_ack(res_is_ack), .res_data(res_data));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Match each host report with the oldest note; an unexpected one never matches
	always @(posedge mclk) begin
		if (res_valid === 1'b1) begin
			cmp_val({res_is_ack, res_data}, notes.size() > 0 ? notes.pop_front() : 9'h1FF);
		end
	end
	// Length of the last programming pulse
	always @(posedge mclk) begin
		run_len <= (prog_busy === 1'b1) ? run_len + 1 : 0;
		if (prog_busy !== 1'b1 && run_len != 0) busy_len <= run_len;
	end
	// Device word with random ignored bits
	function automatic logic [7:0] dev(input logic rw);
		return {4'hA, 3'($random(seed)), rw};
	endfunction
	task automatic send(input logic [7:0] d, input logic a);
		notes.push_back({1'b1, 7'h00, a});
		host.wbyte(d);
	endtask
	task automatic recv(input logic [7:0] d, input logic more);
		notes.push_back({1'b0, d});
		host.rbyte(more);
	endtask
	task automatic rd_at(input logic [7:0] a);
		host.start();
		send(dev(1'b0), 1'b1);
		send(a, 1'b1);
		host.start();
		send(dev(1'b1), 1'b1);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000 && prog_busy !== 1'b0; i++) host.tick(1);
		host.tick(4);
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wp_in = 1'b0;
		for (int i = 0; i < 10; i++) pg[i] = 8'($random(seed));
		b0 = 8'($random(seed));
		repeat (12) @(posedge mclk);
		#1;
		rst = 1'b0;
		host.tick(6);
		cmp_val(standby, 1);
		cmp_val(prog_busy, 0);
		// Byte write to the top address, then time the programming pulse
		host.recover();
		send(dev(1'b0), 1'b1);
		send(8'hFF, 1'b1);
		send(b0, 1'b1);
		host.stop();
		host.tick(6);
		cmp_val(prog_busy, 1);
		cmp_val(standby, 0);
		// Freeze the block mid-programming; the pulse stretches by the frozen cycles
		hold = 8 + ($random(seed) & 15);
		ce = 1'b0;
		host.tick(hold);
		ce = 1'b1;
		cmp_val(prog_busy, 1);
		wait_idle();
		cmp_val(busy_len, WC + hold);
		// Ten bytes into page zero, then a poll while busy
		host.start();
		send(dev(1'b0), 1'b1);
		send(8'h00, 1'b1);
		for (int i = 0; i < 10; i++) send(pg[i], 1'b1);
		host.stop();
		host.start();
		send(dev(1'b0), 1'b0);
		host.stop();
		wait_idle();
		cmp_val(busy_len, WC);
		rd_at(8'h02);
		for (int i = 2; i < 8; i++) recv(pg[i], 1'b1);
		recv(8'hFF, 1'b0);
		host.stop();
		host.tick(8);
		cmp_val(standby, 1);
		// Sequential read across the top of the array
		rd_at(8'hFF);
		recv(b0, 1'b1);
		recv(pg[8], 1'b1);
		recv(pg[9], 1'b0);
		host.stop();
		host.start();
		send(dev(1'b1), 1'b1);
		recv(pg[2], 1'b0);
		host.stop();
		// Foreign device code gets no acknowledge
		host.start();
		send(8'hB0, 1'b0);
		host.stop();
		// Protected write is acknowledged but changes nothing
		wp_in = 1'b1;
		host.start();
		send(dev(1'b0), 1'b1);
		send(8'h02, 1'b1);
		send(~pg[2], 1'b1);
		host.stop();
		host.tick(6);
		cmp_val(prog_busy, 0);
		wp_in = 1'b0;
		rd_at(8'h02);
		recv(pg[2], 1'b0);
		host.stop();
		host.tick(20);
		cmp_val(notes.size(), 0);
		report_and_stop();
	end
	// Watchdog
	initial begin
		repeat (30000) @(posedge mclk);
		error_cnt++;
		report_and_stop();
	end
endmodule
